/* File: shared/bridge_pkg.sv */
// Constants, register map and field layout of the bus bridge transaction engine
package bridge_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_INT_STAT = 4'h1;
	localparam logic [3:0] ADDR_PCI_STAT = 4'h2;
	localparam logic [3:0] ADDR_INT_MASK = 4'h3;
	localparam logic [3:0] ADDR_PCI_MASK = 4'h4;
	localparam logic [3:0] ADDR_WIN_BASE = 4'h5;
	localparam logic [3:0] ADDR_REG_BASE = 4'h6;
	// Control register fields
	localparam int CTL_TO_PCI_PWD   = 0;
	localparam int CTL_TO_PCI_DRD   = 1;
	localparam int CTL_FROM_PCI_PWD = 2;
	localparam int CTL_CMD_SEL      = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Status fields, same layout in both status registers
	localparam int ST_WR_TABT  = 0;
	localparam int ST_WR_MABT  = 1;
	localparam int ST_RD_TABT  = 2;
	localparam int ST_RD_MABT  = 3;
	localparam int ST_PF_DISC  = 4;
	localparam int ST_WR_BERR  = 5;
	localparam int ST_W        = 6;
	localparam logic [5:0] MASK_RESET = 6'h00;
	// Burst and window geometry
	localparam int BURST_MAX   = 16;
	localparam int WIN_BITS    = 21;
	localparam int BLOCK_BITS  = 6;
	// Delayed read hold limit
	localparam int DISCARD_CLKS = 32768;
	// PCI command codes
	localparam logic [3:0] CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] CMD_MEM_WR  = 4'h7;
	localparam logic [3:0] CMD_CFG_RD  = 4'ha;
	localparam logic [3:0] CMD_CFG_WR  = 4'hb;
	localparam logic [3:0] CMD_MEM_RDM = 4'hc;
	localparam logic [3:0] CMD_MEM_RDL = 4'he;
	localparam logic [3:0] CMD_MEM_WRI = 4'hf;
	// Internal bus command kinds
	localparam logic [1:0] IB_IO_WR  = 2'h0;
	localparam logic [1:0] IB_IO_RD  = 2'h1;
	localparam logic [1:0] IB_MEM_WR = 2'h2;
	localparam logic [1:0] IB_MEM_RD = 2'h3;
	// Internal slave answers
	localparam logic [1:0] RSP_WAIT  = 2'h0;
	localparam logic [1:0] RSP_ACK   = 2'h1;
	localparam logic [1:0] RSP_RETRY = 2'h2;
	localparam logic [1:0] RSP_DISC  = 2'h3;
	// PCI master outcomes
	localparam logic [1:0] END_OK   = 2'h0;
	localparam logic [1:0] END_TABT = 2'h1;
	localparam logic [1:0] END_MABT = 2'h2;
endpackage : bridge_pkg

/* File: hw/bus_bridge.sv */
// Transaction engine of the internal bus to PCI bridge
//
// Design decisions made here: the strobed register port and the address map.
module bus_bridge #(
	parameter int DATA_W       = 32,
	parameter int DISCARD_LIM  = bridge_pkg::DISCARD_CLKS
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// Internal bus slave side: requests toward PCI
	input  wire logic              ib_req,
	input  wire logic              ib_write,
	input  wire logic              ib_first,
	input  wire logic [31:0]       ib_addr,
	input  wire logic [3:0]        ib_cmd,
	input  wire logic [DATA_W-1:0] ib_wdata,
	output logic [1:0]             ib_rsp,
	output logic [DATA_W-1:0]      ib_rdata,
	// PCI master engine
	output logic                   pm_start,
	output logic                   pm_write,
	output logic [31:0]            pm_addr,
	output logic [3:0]             pm_cmd,
	output logic [DATA_W-1:0]      pm_wdata,
	input  wire logic              pm_done,
	input  wire logic [1:0]        pm_end,
	input  wire logic [DATA_W-1:0] pm_rdata,
	// PCI target decode
	input  wire logic              pt_req,
	input  wire logic              pt_first,
	input  wire logic [31:0]       pt_addr,
	input  wire logic [3:0]        pt_cmd,
	input  wire logic [DATA_W-1:0] pt_wdata,
	output logic                   pt_claim,
	output logic [1:0]             pt_rsp,
	// Internal bus master side: writes from PCI
	output logic                   im_start,
	output logic [1:0]             im_cmd,
	output logic [31:0]            im_addr,
	output logic [DATA_W-1:0]      im_wdata,
	input  wire logic              im_done,
	input  wire logic              im_berr,
	// Interrupts toward CPU and PCI host
	output logic                   irq_cpu,
	output logic                   irq_pci
);
	import bridge_pkg::*;

	initial begin
		if (DATA_W < 8 || DATA_W > 32 || DISCARD_LIM < 2 || DISCARD_LIM > 65536) $error("bus_bridge: bad parameter");
	end

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001, S_WR = 5'b00010, S_RD = 5'b00100, S_HOLD = 5'b01000, S_DONE = 5'b10000
	} out_e;
	out_e ost_q;

	logic [3:0]        ctrl_q;
	logic [ST_W-1:0]   ist_q, pst_q, imask_q, pmask_q;
	logic [31:0]       win_q, regb_q;
	logic              ostart_q, o_isrd_q, o_nd_q, o_np_q;
	logic [31:0]       oaddr_q;
	logic [3:0]        ocmd_q;
	logic [DATA_W-1:0] odata_q;
	logic [DATA_W-1:0] rbuf_q;
	logic              ib_act_q, ib_wait_q;
	logic [4:0]        ib_cnt_q, pt_cnt_q;
	logic [15:0]       hold_q;
	logic              ipend_q, ibusy_q, istart_q;
	logic [31:0]       iaddr_q;
	logic [DATA_W-1:0] idata_q;
	logic [ST_W-1:0]   set_i, set_p;

	// Position within the aligned address block
	function automatic logic at_block_end(input logic [31:0] a);
		return &a[BLOCK_BITS-1:2];
	endfunction : at_block_end

	// Accepted target command test
	function automatic logic cmd_ok(input logic [3:0] c);
		return c == CMD_MEM_RD || c == CMD_MEM_WR || c == CMD_CFG_RD || c == CMD_CFG_WR ||
			c == CMD_MEM_RDM || c == CMD_MEM_RDL || c == CMD_MEM_WRI;
	endfunction : cmd_ok

	logic in_win, in_regs, is_cfg, pt_wr_cmd, pt_hit, ib_match, ib_burst_end;
	assign in_win  = pt_addr[31:WIN_BITS] == win_q[31:WIN_BITS];
	assign in_regs = pt_addr[31:8] == regb_q[31:8];
	assign is_cfg  = pt_cmd == CMD_CFG_RD || pt_cmd == CMD_CFG_WR;
	assign pt_wr_cmd = pt_cmd == CMD_MEM_WR || pt_cmd == CMD_MEM_WRI;
	// Register hits are served elsewhere, never forwarded through the window
	assign pt_hit  = pt_req && cmd_ok(pt_cmd) && !is_cfg && in_win && !in_regs;
	assign pt_claim = pt_req && cmd_ok(pt_cmd) && (is_cfg || in_win || in_regs);
	assign ib_match = ib_addr == oaddr_q && ib_cmd == ocmd_q;
	assign ib_burst_end = ib_cnt_q == 5'(BURST_MAX - 1) || at_block_end(ib_addr);

	// Register writes and status updates
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			imask_q <= MASK_RESET;
			pmask_q <= MASK_RESET;
			win_q <= '0;
			regb_q <= '0;
			ist_q <= '0;
			pst_q <= '0;
		end else if (ce) begin
			if (reg_wr && reg_addr == ADDR_CTRL) ctrl_q <= reg_wdata[3:0];
			if (reg_wr && reg_addr == ADDR_INT_MASK) imask_q <= reg_wdata[ST_W-1:0];
			if (reg_wr && reg_addr == ADDR_PCI_MASK) pmask_q <= reg_wdata[ST_W-1:0];
			if (reg_wr && reg_addr == ADDR_WIN_BASE) win_q <= {reg_wdata[31:WIN_BITS], 21'h0};
			if (reg_wr && reg_addr == ADDR_REG_BASE) regb_q <= {reg_wdata[31:8], 8'h00};
			// Write one to clear, a new event wins
			ist_q <= (ist_q & ~((reg_wr && reg_addr == ADDR_INT_STAT) ? reg_wdata[ST_W-1:0] : '0)) | set_i;
			pst_q <= (pst_q & ~((reg_wr && reg_addr == ADDR_PCI_STAT) ? reg_wdata[ST_W-1:0] : '0)) | set_p;
		end
	end

	// Register reads, data one cycle later
	always_ff @(posedge clk) begin
		if (rst) reg_rdata <= '0;
		else if (ce) begin
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					ADDR_CTRL:     reg_rdata <= {28'h0, ctrl_q};
					ADDR_INT_STAT: reg_rdata <= {26'h0, ist_q};
					ADDR_PCI_STAT: reg_rdata <= {26'h0, pst_q};
					ADDR_INT_MASK: reg_rdata <= {26'h0, imask_q};
					ADDR_PCI_MASK: reg_rdata <= {26'h0, pmask_q};
					ADDR_WIN_BASE: reg_rdata <= win_q;
					ADDR_REG_BASE: reg_rdata <= regb_q;
					default:       reg_rdata <= '0;
				endcase
			end
		end
	end

	// Masked interrupt outputs
	assign irq_cpu = |(ist_q & ~imask_q);
	assign irq_pci = |(pst_q & ~pmask_q);

	// Status events from PCI outcomes, internal bus errors and discard timer
	always_comb begin
		set_i = '0;
		set_p = '0;
		if (ce && ost_q == S_WR && pm_done && pm_end != END_OK) begin
			set_i[pm_end == END_TABT ? ST_WR_TABT : ST_WR_MABT] = 1'b1;
			set_p[pm_end == END_TABT ? ST_RD_TABT : ST_RD_MABT] = 1'b1;
		end
		if (ce && ost_q == S_RD && pm_done && pm_end != END_OK) begin
			set_i[pm_end == END_TABT ? ST_RD_TABT : ST_RD_MABT] = 1'b1;
			set_p[pm_end == END_TABT ? ST_RD_TABT : ST_RD_MABT] = 1'b1;
		end
		if (ce && ost_q == S_HOLD && 32'(hold_q) >= 32'(DISCARD_LIM - 1) && !(ib_req && !ib_write && ib_match))
			set_p[ST_PF_DISC] = 1'b1;
		if (ce && ibusy_q && im_done && im_berr) begin
			set_i[ST_WR_BERR] = 1'b1;
			set_p[ST_WR_BERR] = 1'b1;
		end
	end

	// Outbound engine: internal bus requests to PCI
	always_ff @(posedge clk) begin
		if (rst) begin
			ost_q <= S_IDLE;
			ostart_q <= 1'b0;
			o_isrd_q <= 1'b0;
			o_nd_q <= 1'b0;
			o_np_q <= 1'b0;
			oaddr_q <= '0;
			ocmd_q <= '0;
			odata_q <= '0;
			rbuf_q <= '0;
			hold_q <= '0;
		end else if (ce) begin
			ostart_q <= 1'b0;
			unique case (ost_q)
				S_IDLE: if (ib_req && ib_first) begin
					// Latch address, command and first word only
					oaddr_q <= ib_addr;
					ocmd_q <= ib_cmd;
					odata_q <= ib_wdata;
					o_isrd_q <= !ib_write;
					o_nd_q <= ctrl_q[CTL_TO_PCI_DRD];
					o_np_q <= ctrl_q[CTL_TO_PCI_PWD];
					ostart_q <= 1'b1;
					ost_q <= ib_write ? S_WR : S_RD;
				end
				S_WR: if (pm_done) ost_q <= o_np_q ? S_DONE : S_IDLE;
				S_RD: if (pm_done) begin
					rbuf_q <= pm_end == END_OK ? pm_rdata : '0;
					hold_q <= '0;
					ost_q <= o_nd_q ? S_DONE : S_HOLD;
				end
				S_HOLD: begin
					hold_q <= hold_q + 16'h1;
					if (ib_req && !ib_write && ib_match) ost_q <= S_IDLE;
					else if (32'(hold_q) >= 32'(DISCARD_LIM - 1)) ost_q <= S_IDLE;
				end
				// One word completes here, a continuation then meets the idle disconnect
				S_DONE: if (ib_req) ost_q <= S_IDLE;
				default: ost_q <= S_IDLE;
			endcase
		end
	end

	// Burst word count on the internal side
	always_ff @(posedge clk) begin
		if (rst) ib_cnt_q <= '0;
		else if (ce) begin
			if (!ib_req || ib_first) ib_cnt_q <= '0;
			else if (ib_rsp == RSP_ACK) ib_cnt_q <= ib_cnt_q + 5'h1;
		end
	end

	// Internal side answer
	always_comb begin
		ib_rsp = RSP_WAIT;
		ib_rdata = rbuf_q;
		if (ib_req) begin
			unique case (ost_q)
				S_IDLE: begin
					if (!ib_first) ib_rsp = RSP_DISC;
					else if (ib_write && !ctrl_q[CTL_TO_PCI_PWD]) ib_rsp = RSP_ACK;
					else if (!ib_write && !ctrl_q[CTL_TO_PCI_DRD]) ib_rsp = RSP_RETRY;
					else ib_rsp = RSP_WAIT;
				end
				S_WR: ib_rsp = (o_np_q && !ib_first) ? RSP_WAIT : RSP_RETRY;
				S_RD: ib_rsp = (o_nd_q && !ib_first) ? RSP_WAIT : RSP_RETRY;
				S_HOLD: begin
					if (!ib_write && ib_match) ib_rsp = ib_burst_end ? RSP_DISC : RSP_ACK;
					else ib_rsp = RSP_RETRY;
				end
				S_DONE: ib_rsp = ib_first ? RSP_RETRY : (o_np_q || !ib_write ? RSP_ACK : RSP_DISC);
				default: ib_rsp = RSP_RETRY;
			endcase
		end
	end

	assign pm_start = ostart_q;
	assign pm_write = ost_q == S_WR;
	assign pm_addr  = oaddr_q;
	assign pm_cmd   = ocmd_q;
	assign pm_wdata = odata_q;

	// Inbound posted write: PCI to internal bus
	always_ff @(posedge clk) begin
		if (rst) begin
			ipend_q <= 1'b0;
			ibusy_q <= 1'b0;
			istart_q <= 1'b0;
			iaddr_q <= '0;
			idata_q <= '0;
			pt_cnt_q <= '0;
		end else if (ce) begin
			istart_q <= 1'b0;
			if (pt_hit && pt_wr_cmd && pt_rsp == RSP_ACK && !ipend_q) begin
				ipend_q <= 1'b1;
				iaddr_q <= pt_addr;
				idata_q <= pt_wdata;
				istart_q <= 1'b1;
				ibusy_q <= 1'b1;
			end else if (ibusy_q && im_done) begin
				ibusy_q <= 1'b0;
				ipend_q <= 1'b0;
			end
			if (!pt_req || pt_first) pt_cnt_q <= '0;
			else if (pt_rsp == RSP_ACK) pt_cnt_q <= pt_cnt_q + 5'h1;
		end
	end

	// Target answer toward PCI
	always_comb begin
		pt_rsp = RSP_WAIT;
		if (pt_hit && pt_wr_cmd) begin
			if (ipend_q) pt_rsp = RSP_RETRY;
			else if (pt_cnt_q == 5'(BURST_MAX - 1) || at_block_end(pt_addr)) pt_rsp = RSP_DISC;
			else if (&pt_addr[WIN_BITS-1:2]) pt_rsp = RSP_DISC;
			else pt_rsp = RSP_ACK;
		end else if (pt_hit) pt_rsp = RSP_RETRY;
	end

	assign im_start = istart_q;
	assign im_cmd   = ctrl_q[CTL_CMD_SEL] ? IB_MEM_WR : IB_IO_WR;
	assign im_addr  = {11'h0, iaddr_q[WIN_BITS-1:0]};
	assign im_wdata = idata_q;

	// Checks
	a_np_wait_done: assert property (@(posedge clk) disable iff (rst)
		ce && ost_q == S_WR && o_np_q && ib_req && !ib_first |-> ib_rsp == RSP_WAIT) else $error("no wait");
	a_np_first_word: assert property (@(posedge clk) disable iff (rst)
		ce && ost_q == S_IDLE && ib_req && ib_first |=> odata_q == $past(ib_wdata)) else $error("word lost");
	a_wr_abort_flag: assert property (@(posedge clk) disable iff (rst)
		ce && ost_q == S_WR && pm_done && pm_end == END_TABT |=> ist_q[ST_WR_TABT] && pst_q[ST_RD_TABT])
		else $error("abort flag");
	a_dr_retry_new: assert property (@(posedge clk) disable iff (rst)
		ib_req && ib_first && !ib_write && ost_q == S_IDLE && !ctrl_q[CTL_TO_PCI_DRD] |-> ib_rsp == RSP_RETRY)
		else $error("no retry");
	a_dr_mismatch: assert property (@(posedge clk) disable iff (rst)
		ost_q == S_HOLD && ib_req && !ib_match |-> ib_rsp == RSP_RETRY) else $error("mismatch served");
	a_burst_cap: assert property (@(posedge clk) disable iff (rst)
		ib_rsp == RSP_ACK |-> ib_cnt_q < 5'(BURST_MAX)) else $error("burst too long");
	a_discard_flag: assert property (@(posedge clk) disable iff (rst)
		ce && ost_q == S_HOLD && set_p[ST_PF_DISC] |=> ost_q == S_IDLE && pst_q[ST_PF_DISC])
		else $error("discard");
	a_abort_zero: assert property (@(posedge clk) disable iff (rst)
		ce && ost_q == S_RD && pm_done && pm_end != END_OK |=> rbuf_q == '0) else $error("nonzero");
	a_cmd_ignore: assert property (@(posedge clk) disable iff (rst)
		pt_req && (pt_cmd[3:1] == 3'h1 || pt_cmd == 4'hd || pt_cmd[3:1] == 3'h0) |-> !pt_claim)
		else $error("ignored cmd");
	a_post_retry: assert property (@(posedge clk) disable iff (rst)
		ipend_q && pt_hit && pt_wr_cmd |-> pt_rsp == RSP_RETRY) else $error("no retry");
	a_cmd_select: assert property (@(posedge clk) disable iff (rst)
		im_start |-> im_cmd == (ctrl_q[CTL_CMD_SEL] ? IB_MEM_WR : IB_IO_WR)) else $error("cmd type");
	a_berr_flag: assert property (@(posedge clk) disable iff (rst)
		ce && ibusy_q && im_done && im_berr |=> ist_q[ST_WR_BERR] && pst_q[ST_WR_BERR]) else $error("berr");
	c_delayed_read: cover property (@(posedge clk) ost_q == S_HOLD && ib_rsp == RSP_ACK);
	c_np_write: cover property (@(posedge clk) ost_q == S_DONE && o_np_q);
	c_post_in: cover property (@(posedge clk) im_start);
endmodule : bus_bridge

/* File: tb/bridge_far_model.sv */
// Behavioural far side: PCI target for the master engine and internal slave for window writes
module bridge_far_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  dly,
	input  wire logic [1:0]  end_code,
	input  wire logic        berr,
	input  wire logic        pm_start,
	input  wire logic        pm_write,
	input  wire logic [31:0] pm_addr,
	input  wire logic [31:0] pm_wdata,
	output logic             pm_done,
	output logic [1:0]       pm_end,
	output logic [31:0]      pm_rdata,
	input  wire logic        im_start,
	input  wire logic [1:0]  im_cmd,
	input  wire logic [31:0] im_addr,
	input  wire logic [31:0] im_wdata,
	output logic             im_done,
	output logic             im_berr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cap_addr, cap_wdata, cap_iaddr, cap_idata;
	logic        cap_write;
	logic [1:0]  cap_icmd;
	int          pm_cnt = 0;
	int          im_cnt = 0;
	// Idle outputs
	initial begin
		pm_done = 1'b0;
		pm_end = 2'h3;
		pm_rdata = 32'h0;
		im_done = 1'b0;
		im_berr = 1'b0;
	end
	// PCI target: ends each op after dly clocks; data line toggles once released
	always begin
		@(posedge clk);
		if (pm_start === 1'b1 && !rst) begin
			cap_addr = pm_addr;
			cap_write = pm_write;
			cap_wdata = pm_wdata;
			repeat (dly) @(posedge clk);
			pm_done <= 1'b1;
			pm_end <= end_code;
			pm_rdata <= cap_write ? ~pm_rdata : cap_addr ^ 32'h5a5a_0000;
			@(posedge clk);
			pm_done <= 1'b0;
			pm_end <= ~end_code;
			pm_rdata <= ~pm_rdata;
			pm_cnt++;
		end
	end
	// Internal slave: takes a window write, answers after dly clocks, bus error on request
	always begin
		@(posedge clk);
		if (im_start === 1'b1 && !rst) begin
			cap_icmd = im_cmd;
			cap_iaddr = im_addr;
			cap_idata = im_wdata;
			repeat (dly) @(posedge clk);
			im_done <= 1'b1;
			im_berr <= berr;
			@(posedge clk);
			im_done <= 1'b0;
			im_berr <= 1'b0;
			im_cnt++;
		end
	end
endmodule : bridge_far_model

/* File: tb/bus_bridge_tb.sv */
// Self-checking bench for the bus bridge transaction engine
module bus_bridge_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bridge_pkg::*;
	localparam int DLIM = 64;
	localparam logic [31:0] WBASE = 32'h4000_0000;
	logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, ib_req = 0, ib_write = 0, ib_first = 0;
	logic pt_req = 0, pt_first = 0, far_berr = 0, rd_q = 0, claim;
	logic [3:0] reg_addr = 0, ib_cmd = 0, pt_cmd = 0, pm_cmd;
	logic [31:0] reg_wdata = 0, ib_addr = 0, ib_wdata = 0, pt_addr = 0, pt_wdata = 0;
	logic [31:0] reg_rdata, ib_rdata, pm_addr, pm_wdata, pm_rdata, im_addr, im_wdata, seen, a, d;
	logic [1:0] ib_rsp, pt_rsp, pm_end, im_cmd, rsp, far_end = 0;
	logic [7:0] far_dly = 8'h06;
	logic pm_start, pm_write, pm_done, pt_claim, im_start, im_done, im_berr, irq_cpu, irq_pci;
	logic [31:0] exp_q[$];
	logic [1:0] ends[3];
	logic [3:0] cmds[6];
	int fail_count = 0, total_checks = 0, waits, c0;

	bus_bridge #(.DISCARD_LIM(DLIM)) i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ib_req(ib_req),
		.ib_write(ib_write), .ib_first(ib_first), .ib_addr(ib_addr), .ib_cmd(ib_cmd), .ib_wdata(ib_wdata),
		.ib_rsp(ib_rsp), .ib_rdata(ib_rdata), .pm_start(pm_start), .pm_write(pm_write), .pm_addr(pm_addr),
		.pm_cmd(pm_cmd), .pm_wdata(pm_wdata), .pm_done(pm_done), .pm_end(pm_end), .pm_rdata(pm_rdata),
		.pt_req(pt_req), .pt_first(pt_first), .pt_addr(pt_addr), .pt_cmd(pt_cmd), .pt_wdata(pt_wdata),
		.pt_claim(pt_claim), .pt_rsp(pt_rsp), .im_start(im_start), .im_cmd(im_cmd), .im_addr(im_addr),
		.im_wdata(im_wdata), .im_done(im_done), .im_berr(im_berr), .irq_cpu(irq_cpu), .irq_pci(irq_pci));
	bridge_far_model i_far (.clk(clk), .rst(rst), .dly(far_dly), .end_code(far_end), .berr(far_berr),
		.pm_start(pm_start), .pm_write(pm_write), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_done(pm_done),
		.pm_end(pm_end), .pm_rdata(pm_rdata), .im_start(im_start), .im_cmd(im_cmd), .im_addr(im_addr),
		.im_wdata(im_wdata), .im_done(im_done), .im_berr(im_berr));

	always #10 clk = ~clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict();
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// Read data are checked against the oldest note one cycle after the strobe
	always @(posedge clk) begin
		if (rd_q) check(reg_rdata, exp_q.pop_front());
		rd_q <= reg_rd;
	end
	task automatic reg_write(input logic [3:0] ad, input logic [31:0] wd);
		reg_addr <= ad;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : reg_write
	task automatic reg_read(input logic [3:0] ad, input logic [31:0] exp);
		exp_q.push_back(exp);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : reg_read
	// Internal master: holds the word until any answer but wait, then lets go (ends on ack, retry or disconnect)
	task automatic ib_op(input logic w, input logic [31:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		waits = 0;
		ib_req <= 1'b1;
		ib_write <= w;
		ib_first <= 1'b1;
		ib_addr <= ad;
		ib_cmd <= w ? CMD_MEM_WR : CMD_MEM_RD;
		ib_wdata <= wd;
		do begin
			@(negedge clk);
			rsp = ib_rsp;
			seen = ib_rdata;
			if (rsp === RSP_WAIT) waits++;
			@(posedge clk);
			ib_first <= 1'b0;
			n++;
		end while (rsp === RSP_WAIT && n < 300);
		ib_req <= 1'b0;
		@(posedge clk);
	endtask : ib_op
	// Internal master tries one continuation word of a finished transaction
	task automatic ib_cont(input logic w, input logic [31:0] ad);
		ib_req <= 1'b1;
		ib_write <= w;
		ib_first <= 1'b0;
		ib_addr <= ad;
		@(negedge clk);
		rsp = ib_rsp;
		@(posedge clk);
		ib_req <= 1'b0;
		@(posedge clk);
	endtask : ib_cont
	task automatic pt_op(input logic [3:0] c, input logic [31:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		pt_req <= 1'b1;
		pt_first <= 1'b1;
		pt_cmd <= c;
		pt_addr <= ad;
		pt_wdata <= wd;
		do begin
			@(negedge clk);
			rsp = pt_rsp;
			claim = pt_claim;
			@(posedge clk);
			n++;
		end while (rsp === RSP_WAIT && claim === 1'b1 && n < 300);
		pt_req <= 1'b0;
		@(posedge clk);
	endtask : pt_op
	task automatic wait_cnt(input bit im);
		int n;
		n = 0;
		while ((im ? i_far.im_cnt : i_far.pm_cnt) == c0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		check(32'(n < 500), 32'h1);
	endtask : wait_cnt
	task automatic stat_check(input logic [5:0] ist, input logic [5:0] pst);
		reg_read(ADDR_INT_STAT, 32'(ist));
		reg_read(ADDR_PCI_STAT, 32'(pst));
		check(32'({irq_cpu, irq_pci}), 32'({ist != 0, pst != 0}));
		reg_write(ADDR_INT_STAT, 32'h3f);
		reg_write(ADDR_PCI_STAT, 32'h3f);
	endtask : stat_check

	initial begin
		#1_000_000;
		fail_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h4485));
		ends = '{END_OK, END_TABT, END_MABT};
		cmds = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd, CMD_MEM_WR};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) reg_read(4'(i), 32'h0);
		reg_read(4'hf, 32'h0);
		// Frozen clock enable must ignore a register write
		ce <= 1'b0;
		reg_write(ADDR_CTRL, 32'h5);
		ce <= 1'b1;
		reg_read(ADDR_CTRL, 32'h0);
		// Non-posted writes, each ending
		foreach (ends[i]) begin
			far_end <= ends[i];
			reg_write(ADDR_CTRL, 32'h1);
			a = 32'h1000_0000 | ($urandom & 32'hfc);
			d = $urandom;
			ib_op(1'b1, a, d);
			check(32'(rsp), 32'(RSP_ACK));
			check(32'(waits > 0), 32'h1);
			check(i_far.cap_wdata, d);
			ib_cont(1'b1, a + 4);
			check(32'(rsp), 32'(RSP_DISC));
			stat_check(i == 1 ? 6'h01 : i == 2 ? 6'h02 : 6'h0, i == 1 ? 6'h04 : i == 2 ? 6'h08 : 6'h0);
		end
		// Posted write, a second one retried while the first is on PCI
		far_end <= END_OK;
		far_dly <= 8'h14;
		reg_write(ADDR_CTRL, 32'h0);
		c0 = i_far.pm_cnt;
		ib_op(1'b1, a, d);
		check(32'(rsp), 32'(RSP_ACK));
		ib_op(1'b1, a + 4, d);
		check(32'(rsp), 32'(RSP_RETRY));
		wait_cnt(1'b0);
		check(i_far.cap_addr, a);
		far_dly <= 8'h06;
		// Delayed reads: plain then target abort
		for (int i = 0; i < 2; i++) begin
			far_end <= ends[i];
			a = 32'h1000_0000 | ($urandom & 32'hfc);
			c0 = i_far.pm_cnt;
			ib_op(1'b0, a, 32'h0);
			check(32'(rsp), 32'(RSP_RETRY));
			wait_cnt(1'b0);
			ib_op(1'b0, a ^ 32'h100, 32'h0);
			check(32'(rsp), 32'(RSP_RETRY));
			ib_op(1'b0, a, 32'h0);
			check(32'(rsp), 32'(RSP_ACK));
			check(seen, i == 0 ? a ^ 32'h5a5a_0000 : 32'h0);
			stat_check(i == 1 ? 6'h04 : 6'h0, i == 1 ? 6'h04 : 6'h0);
		end
		// Unclaimed delayed read is discarded
		far_end <= END_OK;
		c0 = i_far.pm_cnt;
		ib_op(1'b0, a, 32'h0);
		wait_cnt(1'b0);
		repeat (DLIM + 8) @(posedge clk);
		reg_write(ADDR_PCI_MASK, 32'h3f);
		check(32'(irq_pci), 32'h0);
		reg_write(ADDR_PCI_MASK, 32'h0);
		stat_check(6'h0, 6'h10);
		c0 = i_far.pm_cnt;
		ib_op(1'b0, a | 32'h3c, 32'h0);
		check(32'(rsp), 32'(RSP_RETRY));
		wait_cnt(1'b0);
		ib_op(1'b0, a | 32'h3c, 32'h0);
		check(32'(rsp), 32'(RSP_DISC));
		// Non-delayed reads: plain then master abort
		reg_write(ADDR_CTRL, 32'h2);
		for (int i = 0; i < 3; i += 2) begin
			far_end <= ends[i];
			ib_op(1'b0, a, 32'h0);
			check(32'(rsp), 32'(RSP_ACK));
			check(seen, i == 0 ? a ^ 32'h5a5a_0000 : 32'h0);
			ib_cont(1'b0, a + 4);
			check(32'(rsp), 32'(RSP_DISC));
			stat_check(i == 2 ? 6'h08 : 6'h0, i == 2 ? 6'h08 : 6'h0);
		end
		// Window writes from PCI, I/O then memory command kind, last one with a bus error
		reg_write(ADDR_WIN_BASE, WBASE);
		reg_write(ADDR_REG_BASE, WBASE | 32'h0010_0000);
		reg_read(ADDR_WIN_BASE, WBASE);
		for (int s = 0; s < 3; s++) begin
			far_berr <= (s == 2);
			reg_write(ADDR_CTRL, s == 0 ? 32'h0 : 32'h8);
			a = $urandom & 32'h0007_ffc0;
			d = $urandom;
			c0 = i_far.im_cnt;
			pt_op(CMD_MEM_WR, WBASE + a, d);
			check(32'({claim, rsp}), 32'({1'b1, RSP_ACK}));
			pt_op(CMD_MEM_WR, WBASE + a + 64, d);
			check(32'(rsp), 32'(RSP_RETRY));
			wait_cnt(1'b1);
			check(32'(i_far.cap_icmd), 32'(s == 0 ? IB_IO_WR : IB_MEM_WR));
			check(i_far.cap_iaddr, a);
			check(i_far.cap_idata, d);
			stat_check(s == 2 ? 6'h20 : 6'h0, s == 2 ? 6'h20 : 6'h0);
		end
		// Register block is claimed but never forwarded to the internal bus
		c0 = i_far.im_cnt;
		foreach (cmds[i]) begin
			pt_op(cmds[i], i == 5 ? WBASE | 32'h0010_0000 : WBASE, 32'h0);
			check(32'(claim), 32'(i == 5));
		end
		check(32'(i_far.im_cnt - c0), 32'h0);
		pt_op(CMD_MEM_WR, WBASE | 32'h001f_fffc, d);
		check(32'(rsp), 32'(RSP_DISC));
		pt_op(CMD_MEM_WR, WBASE | 32'h0000_003c, d);
		check(32'(rsp), 32'(RSP_DISC));
		pt_op(CMD_MEM_WR, 32'h2000_0000, 32'h0);
		check(32'(claim), 32'h0);
		give_verdict();
	end
endmodule : bus_bridge_tb
